//--- logic/dram_cfg_pkg.sv
// Constants, tables and carrier types for the latency and burst configuration block
package dram_cfg_pkg;

   // Mode register address and field layout
   localparam logic [5:0] LATENCY_REG_ADDR  = 6'h02;
   localparam int         LEVEL_BIT         = 7;
   localparam int         SET_SEL_BIT       = 6;
   localparam int         WL_MSB            = 5;
   localparam int         WL_LSB            = 3;
   localparam int         RL_MSB            = 2;
   localparam int         RL_LSB            = 0;
   localparam logic [7:0] LATENCY_REG_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ     = 8'h00;

   // Burst geometry, beats counted from zero
   localparam logic [4:0] LAST_BEAT_BL16 = 5'h0f;
   localparam logic [4:0] LAST_BEAT_BL32 = 5'h1f;

   typedef logic [7:0] cyc_t;

   // Extra read-to-precharge clocks for 32-beat bursts
   localparam cyc_t BL32_RTP_EXTRA = 8'h08;

   // Latency tables indexed by the 3-bit field code
   localparam cyc_t RL_PLAIN [8] = '{8'h06, 8'h0a, 8'h0e, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24};
   localparam cyc_t RL_INV   [8] = '{8'h06, 8'h0c, 8'h10, 8'h16, 8'h1c, 8'h20, 8'h24, 8'h28};
   localparam cyc_t WL_SET_A [8] = '{8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h0e, 8'h10, 8'h12};
   localparam cyc_t WL_SET_B [8] = '{8'h04, 8'h08, 8'h0c, 8'h12, 8'h16, 8'h1a, 8'h1e, 8'h22};
   localparam cyc_t RTP_TAB  [8] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h0a, 8'h0c, 8'h0e, 8'h10};
   localparam cyc_t WR_TAB   [8] = '{8'h06, 8'h0a, 8'h10, 8'h14, 8'h18, 8'h1e, 8'h22, 8'h28};

   // Mode-register command from the controller
   typedef struct packed {
      logic       wr_en;
      logic       rd_en;
      logic [5:0] addr;
      logic [7:0] data;
   } mode_cmd_t;

   // Column command; column bits 9..2 only, the two lowest never travel
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic       other;
      logic       burst32;
      logic       auto_precharge;
      logic [7:0] col_hi;
   } col_cmd_t;

   // Timing presently in force
   typedef struct packed {
      cyc_t read_latency;
      cyc_t write_latency;
      cyc_t read_to_precharge_cycles;
      cyc_t write_recovery_cycles;
   } timing_t;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_LATENCY = 2'b01,
      ST_BEATS   = 2'b11,
      ST_RECOVER = 2'b10
   } burst_state_t;

endpackage

//--- logic/dram_latency_burst_config.sv
// Latency mode register with two set points, burst beat ordering and auto-precharge timing
// Summary of operation
// - The two lowest column bits are zero and never carried on the bus.
// - Write beats run sequentially from zero to 0xf or 0x1f, never wrapping.
// - Without inversion, read latency codes give 6,10,14,20,24,28,32,36; default zero.
// - With inversion, read latency codes give 6,12,16,22,28,32,36,40.
// - Read-to-precharge is 8 for codes 0-3, then 10,12,14,16.
// - Set A write latency codes give 4 to 18 in steps of two.
// - Set B write latency codes give 4,8,12,18,22,26,30,34.
// - Bit 6 picks write latency set; bits 5:3 write, 2:0 read latency.
// - Leveling bit set by mode write holds until a mode write clears it.
// - Mode writes and reads reach only the copy the write select picks.
// - Operation uses only the copy the operate select picks.
// - 32-beat reads add eight clocks before automatic precharge.
// - Write auto-precharge starts after the write recovery count elapses.
// - Read inversion enable chooses which read latency column applies.
`timescale 1ns/1ps
module dram_latency_burst_config
   import dram_cfg_pkg::*;
(
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         reset_n,
   // Commands from the controller
   input  wire mode_cmd_t    mode_cmd,
   input  wire col_cmd_t     col_cmd,
   // Bits held in other mode registers
   input  wire logic         setpoint_write_select,
   input  wire logic         setpoint_operate_select,
   input  wire logic         read_inversion_enable,
   input  wire logic [2:0]   write_recovery_code,
   // Mode read answer
   output logic [7:0]        mode_rdata_q,
   output logic              mode_rvalid_q,
   // Status and timing in force
   output timing_t           timing_q,
   output logic              leveling_active_q,
   output logic              align_error_q,
   // Burst engine outputs
   output logic              write_beat_valid_q,
   output logic [4:0]        write_beat_addr_q,
   output logic              precharge_start_q
);

   logic [7:0]   setpoint_q [2];
   logic [7:0]   active_reg;
   logic [2:0]   rl_code;
   logic [2:0]   wl_code;
   burst_state_t state_q;
   cyc_t         cnt_q;
   logic [4:0]   last_beat_q;
   logic         ap_q;
   logic         mrw_hit;
   logic         cmd_open;

   assign mrw_hit  = mode_cmd.wr_en && (mode_cmd.addr == LATENCY_REG_ADDR);
   // Leveling shuts out everything but mode writes
   assign cmd_open = !leveling_active_q;

   // Set-point copies, reached through the write select only
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         setpoint_q[0] <= LATENCY_REG_RESET;
         setpoint_q[1] <= LATENCY_REG_RESET;
      end else if (mrw_hit) begin
         setpoint_q[setpoint_write_select] <= mode_cmd.data;
      end
   end

   // Leveling state follows the leveling bit of each mode write to the latency register
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         leveling_active_q <= 1'b0;
      end else if (mrw_hit) begin
         leveling_active_q <= mode_cmd.data[LEVEL_BIT];
      end
   end

   // Mode read answer one cycle after the request
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         mode_rdata_q  <= UNMAPPED_READ;
         mode_rvalid_q <= 1'b0;
      end else begin
         mode_rvalid_q <= mode_cmd.rd_en && cmd_open;
         if (mode_cmd.rd_en && cmd_open) begin
            mode_rdata_q <= (mode_cmd.addr == LATENCY_REG_ADDR) ?
                            setpoint_q[setpoint_write_select] : UNMAPPED_READ;
         end
      end
   end

   assign active_reg = setpoint_q[setpoint_operate_select];
   assign rl_code    = active_reg[RL_MSB:RL_LSB];
   assign wl_code    = active_reg[WL_MSB:WL_LSB];

   // Timing lookup, registered so it leaves straight from flops
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         timing_q <= '{RL_PLAIN[0], WL_SET_A[0], RTP_TAB[0], WR_TAB[0]};
      end else begin
         timing_q.read_latency <= read_inversion_enable ? RL_INV[rl_code] : RL_PLAIN[rl_code];
         timing_q.write_latency <= active_reg[SET_SEL_BIT] ? WL_SET_B[wl_code] : WL_SET_A[wl_code];
         timing_q.read_to_precharge_cycles <= RTP_TAB[rl_code];
         timing_q.write_recovery_cycles    <= WR_TAB[write_recovery_code];
      end
   end

   // Flags writes whose start address the controller failed to align
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         align_error_q <= 1'b0;
      end else begin
         align_error_q <= col_cmd.wr && cmd_open && (state_q == ST_IDLE) &&
                          ((col_cmd.col_hi[1:0] != 2'b00) ||
                           (col_cmd.burst32 && col_cmd.col_hi[2]));
      end
   end

   // Burst engine; commands arriving while busy are dropped, the controller spaces them
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         state_q            <= ST_IDLE;
         cnt_q              <= '0;
         last_beat_q        <= LAST_BEAT_BL16;
         ap_q               <= 1'b0;
         write_beat_valid_q <= 1'b0;
         write_beat_addr_q  <= '0;
         precharge_start_q  <= 1'b0;
      end else begin
         write_beat_valid_q <= 1'b0;
         precharge_start_q  <= 1'b0;
         unique case (state_q)
            ST_IDLE: begin
               if (cmd_open && col_cmd.wr) begin
                  state_q     <= ST_LATENCY;
                  cnt_q       <= timing_q.write_latency - 8'h01;
                  last_beat_q <= col_cmd.burst32 ? LAST_BEAT_BL32 : LAST_BEAT_BL16;
                  ap_q        <= col_cmd.auto_precharge;
               end else if (cmd_open && col_cmd.rd && col_cmd.auto_precharge) begin
                  state_q <= ST_RECOVER;
                  cnt_q   <= timing_q.read_to_precharge_cycles - 8'h01 +
                             (col_cmd.burst32 ? BL32_RTP_EXTRA : 8'h00);
               end
            end
            ST_LATENCY: begin
               cnt_q <= cnt_q - 8'h01;
               if (cnt_q == 8'h00) begin
                  state_q            <= ST_BEATS;
                  write_beat_valid_q <= 1'b1;
                  write_beat_addr_q  <= 5'h00;
               end
            end
            ST_BEATS: begin
               if (write_beat_addr_q == last_beat_q) begin
                  state_q <= ap_q ? ST_RECOVER : ST_IDLE;
                  cnt_q   <= timing_q.write_recovery_cycles - 8'h01;
               end else begin
                  write_beat_valid_q <= 1'b1;
                  write_beat_addr_q  <= write_beat_addr_q + 5'h01;
               end
            end
            ST_RECOVER: begin
               cnt_q <= cnt_q - 8'h01;
               if (cnt_q == 8'h00) begin
                  state_q           <= ST_IDLE;
                  precharge_start_q <= 1'b1;
               end
            end
         endcase
      end
   end

   // Checks on the logic above
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   sequence s_mrr_req;
      mode_cmd.rd_en && !leveling_active_q && (mode_cmd.addr == LATENCY_REG_ADDR);
   endsequence

   sequence s_lev_on;
      mrw_hit && mode_cmd.data[LEVEL_BIT];
   endsequence

   sequence s_beat_step;
      write_beat_valid_q && (write_beat_addr_q != last_beat_q);
   endsequence

   AST_MRR_COPY: assert property (
      s_mrr_req |=> mode_rvalid_q && mode_rdata_q == $past(setpoint_q[setpoint_write_select]))
      else $error("mode read did not return the selected copy");

   AST_LEVEL_HOLD: assert property (
      s_lev_on ##1 !mrw_hit |=> leveling_active_q)
      else $error("leveling state dropped without a mode write");

   AST_LEVEL_BLOCK: assert property (
      leveling_active_q && (state_q == ST_IDLE) |=> state_q == ST_IDLE)
      else $error("command accepted during leveling");

   AST_RL_PLAIN: assert property (
      !read_inversion_enable ##1 1'b1 |-> timing_q.read_latency == RL_PLAIN[$past(rl_code)])
      else $error("plain read latency wrong");

   AST_RL_INV: assert property (
      read_inversion_enable ##1 1'b1 |-> timing_q.read_latency == RL_INV[$past(rl_code)])
      else $error("inverted read latency wrong");

   AST_WL_SET: assert property (
      active_reg[SET_SEL_BIT] ##1 1'b1 |-> timing_q.write_latency == WL_SET_B[$past(wl_code)])
      else $error("set B write latency wrong");

   AST_RTP: assert property (
      ##1 1'b1 |-> timing_q.read_to_precharge_cycles == RTP_TAB[$past(rl_code)])
      else $error("read to precharge count wrong");

   AST_INACTIVE_FREE: assert property (
      mrw_hit && (setpoint_write_select != setpoint_operate_select) &&
      $stable(setpoint_operate_select) ##1 $stable(setpoint_operate_select) &&
      $stable(read_inversion_enable) && $stable(write_recovery_code)
      |=> $stable(timing_q))
      else $error("inactive copy write changed timing");

   AST_BEAT_SEQ: assert property (
      s_beat_step |=> write_beat_valid_q && write_beat_addr_q == $past(write_beat_addr_q) + 5'h01)
      else $error("write beat sequence broken");

   AST_BEAT_START: assert property (
      $rose(write_beat_valid_q) |-> write_beat_addr_q == 5'h00)
      else $error("write burst did not start at beat zero");

   AST_RD32_AP: assert property (
      (state_q == ST_IDLE) && cmd_open && !col_cmd.wr && col_cmd.rd &&
      col_cmd.auto_precharge && col_cmd.burst32
      |=> cnt_q == $past(timing_q.read_to_precharge_cycles) + 8'h07)
      else $error("long read precharge count wrong");

endmodule // dram_latency_burst_config

//--- verification/mem_ctrl_model.sv
// Memory controller model issuing mode-register and column commands
`timescale 1ns/1ps
module mem_ctrl_model
   import dram_cfg_pkg::*;
(
   // Clock
   input  wire logic core_clk,
   // Commands to the device
   output mode_cmd_t mode_cmd,
   output col_cmd_t  col_cmd
);
   // row for a 25 MHz clock
   localparam int BAND_CODE = 0;

   // Quiet bus at start
   initial begin
      mode_cmd = '0;
      col_cmd  = '0;
   end

   // leveling left only by a clearing write
   // Idle fields carry inverted data so a stale value never passes
   task automatic mode_req(input logic wr, input logic [5:0] a, input logic [7:0] d);
      @(posedge core_clk);
      mode_cmd <= '{wr, !wr, a, d};
      @(posedge core_clk);
      mode_cmd <= '{1'b0, 1'b0, ~a, ~d};
   endtask

   task automatic col_req(input logic wr, input logic b32, input logic ap, input logic [7:0] col);
      logic [7:0] c;
      c = wr ? {col[7:3], col[2] & !b32, 2'b00} : col;
      @(posedge core_clk);
      col_cmd <= '{!wr, wr, 1'b0, b32, ap, c};
      @(posedge core_clk);
      col_cmd <= '{1'b0, 1'b0, 1'b0, ~b32, ~ap, ~c};
   endtask

   // Unaligned write on purpose, so the device's alignment flag is exercised
   task automatic col_bad(input logic b32, input logic [7:0] col);
      @(posedge core_clk);
      col_cmd <= '{1'b0, 1'b1, 1'b0, b32, 1'b0, col};
      @(posedge core_clk);
      col_cmd <= '{1'b0, 1'b0, 1'b0, ~b32, 1'b1, ~col};
   endtask
endmodule // mem_ctrl_model

//--- verification/dram_latency_burst_config_bench.sv
// Self-checking bench for the latency and burst configuration block
`timescale 1ns/1ps
module dram_latency_burst_config_bench;
   import dram_cfg_pkg::*;
   logic       core_clk = 1'b0;
   logic       reset_n  = 1'b0;
   logic       sel_wr   = 1'b0;
   logic       sel_op   = 1'b0;
   logic       inv      = 1'b0;
   logic [2:0] wr_code  = 3'h0;
   mode_cmd_t  mode_cmd;
   col_cmd_t   col_cmd;
   timing_t    tq;
   logic [7:0] rdata;
   logic [4:0] baddr;
   logic       rvalid, lvl, bvalid, pre, aerr;
   int         n_mismatch = 0;
   int         cmp_count  = 0;
   int         copy_v [2] = '{0, 0};
   // Reference latency tables
   int rl_a [8] = '{6, 10, 14, 20, 24, 28, 32, 36};
   int rl_b [8] = '{6, 12, 16, 22, 28, 32, 36, 40};
   int wl_a [8] = '{4, 6, 8, 10, 12, 14, 16, 18};
   int wl_b [8] = '{4, 8, 12, 18, 22, 26, 30, 34};
   int rtp  [8] = '{8, 8, 8, 8, 10, 12, 14, 16};
   int wrc  [8] = '{6, 10, 16, 20, 24, 30, 34, 40};

   // 25 MHz clock
   always #20 core_clk = ~core_clk;

   mem_ctrl_model u_ctrl (.core_clk, .mode_cmd, .col_cmd);

   dram_latency_burst_config u_dut (
      .core_clk, .reset_n, .mode_cmd, .col_cmd,
      .setpoint_write_select(sel_wr), .setpoint_operate_select(sel_op),
      .read_inversion_enable(inv), .write_recovery_code(wr_code),
      .mode_rdata_q(rdata), .mode_rvalid_q(rvalid), .timing_q(tq),
      .leveling_active_q(lvl), .align_error_q(aerr), .write_beat_valid_q(bvalid),
      .write_beat_addr_q(baddr), .precharge_start_q(pre));

   // Timing expected from the copy in force
   function automatic logic [31:0] exp_t();
      int v;
      v = copy_v[sel_op];
      return {8'(inv ? rl_b[v % 8] : rl_a[v % 8]),
              8'(v[6] ? wl_b[(v >> 3) % 8] : wl_a[(v >> 3) % 8]),
              8'(rtp[v % 8]), 8'(wrc[wr_code])};
   endfunction

   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic mwr(input logic [7:0] d);
      u_ctrl.mode_req(1'b1, 6'h02, d);
      copy_v[sel_wr] = d;
      repeat (2) @(posedge core_clk);
      #1;
      chk("timing", tq, exp_t());
      chk("leveling", lvl, d[7]);
   endtask

   task automatic mread(input logic [5:0] a);
      u_ctrl.mode_req(1'b0, a, 8'h00);
      // Answer stands only in the cycle after the take edge
      #1;
      chk("rvalid", rvalid, 1'b1);
      chk("rdata", rdata, a == 6'h02 ? 8'(copy_v[sel_wr]) : 8'h00);
   endtask

   // One burst with auto-precharge; bounded wait for the precharge pulse
   task automatic burst(input logic wr, input logic b32);
      logic [31:0] e;
      int n;
      e = exp_t();
      u_ctrl.col_req(wr, b32, 1'b1, 8'($urandom));
      #1;
      chk("align flag", aerr, 1'b0);
      if (wr) begin
         // Beat zero stands write latency edges after the take edge
         repeat (e[23:16] - 1) @(posedge core_clk);
         for (int b = 0; b <= (b32 ? 31 : 15); b++) begin
            @(posedge core_clk);
            #1;
            chk("beat", {bvalid, baddr}, {1'b1, 5'(b)});
         end
      end
      for (n = 1; n < 200; n++) begin
         @(posedge core_clk);
         #1;
         if (pre === 1'b1) break;
      end
      chk("precharge", n, wr ? e[7:0] + 1 : e[15:8] + 8 * b32);
      if (n == 200) wrap_up();
   endtask

   // Main sequence
   initial begin
      int n;
      void'($urandom(96613));
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      #1;
      chk("reset timing", tq, 32'h06040806);
      mread(6'h02);
      mread(6'h05);
      // Every code of every table, random recovery code
      for (int i = 0; i < 16; i++) begin
         @(posedge core_clk);
         inv     <= i[3];
         wr_code <= 3'($urandom);
         mwr({1'b0, i[3], 3'(i + 3), 3'(i)});
         mread(6'h02);
      end
      // Inactive copy rewritten, then made active
      @(posedge core_clk);
      sel_wr <= 1'b1;
      mwr(8'($urandom) & 8'h7f);
      mread(6'h02);
      @(posedge core_clk);
      sel_op <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      chk("switched", tq, exp_t());
      // Bursts in all four kinds
      for (int k = 0; k < 4; k++) burst(k[0], k[1]);
      // Leveling blocks reads and bursts until cleared
      mwr(8'h80);
      u_ctrl.mode_req(1'b0, 6'h02, 8'h00);
      #1;
      chk("refused read", rvalid, 1'b0);
      u_ctrl.col_req(1'b1, 1'b0, 1'b0, 8'h00);
      n = 0;
      repeat (40) begin
         @(posedge core_clk);
         #1;
         if (bvalid !== 1'b0) n++;
      end
      chk("dropped burst", n, 0);
      mwr(8'h00);
      burst(1'b1, 1'b0);
      // Misaligned writes must raise the flag in the cycle after the take edge
      for (int k = 0; k < 2; k++) begin
         u_ctrl.col_bad(k[0], k[0] ? ((8'($urandom) & 8'hfc) | 8'h04) : (8'($urandom) | 8'h01));
         #1;
         chk("align flag", aerr, 1'b1);
         repeat (60) @(posedge core_clk);
      end
      wrap_up();
   end

   // Hang guard
   initial begin
      #4000000;
      n_mismatch++;
      wrap_up();
   end
endmodule // dram_latency_burst_config_bench
